/* nvm_access_ctrl.sv */
// controller end: registers, array, program timing, core stalls
`timescale 1ns/100ps
`include "nvm_params.svh"
module nvm_access_ctrl #(
  parameter int DEPTH = 512,
  parameter int ATOMIC_CYC = `NVM_ATOMIC_CYC,
  parameter int SPLIT_CYC = `NVM_SPLIT_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  nvm_io_if.device bus,
  output logic o_busy
);
  localparam int AW = $clog2(DEPTH);
  // =====================================
  // state
  logic [7:0] mem [DEPTH];
  logic [8:0] addr_q;
  logic [7:0] data_q;
  nvm_pkg::prog_mode_t mode_q;
  logic rie_q;
  logic [2:0] arm_cnt_q;
  logic trig_q = 1'b0;
  logic [31:0] prog_cnt_q = 32'h0;
  logic [7:0] prog_data_q;
  logic [2:0] stall_q;
  logic [7:0] ctrl_rd;
  logic wr_ctrl;
  logic start;

  assign wr_ctrl = bus.io_wr && bus.io_addr == `NVM_OFS_CONTROL;
  // start needs a live arm at the trigger write
  assign start = wr_ctrl && bus.io_wdata[`NVM_BIT_TRIG] && !trig_q && arm_cnt_q != 3'h0 && mode_q != nvm_pkg::MODE_RSVD; // R10 R18
  assign o_busy = trig_q;

  // =====================================
  // address and data
  // address has no reset: undefined until software loads it
  always_ff @(posedge i_ref_clk) begin
    if (bus.io_wr && !trig_q && bus.io_addr == `NVM_OFS_ADDR_LO) begin // R15 R3
      addr_q[7:0] <= bus.io_wdata;
    end
    if (bus.io_wr && !trig_q && bus.io_addr == `NVM_OFS_ADDR_HI) begin // R15 R3
      addr_q[8] <= bus.io_wdata[0];
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      data_q <= `NVM_DATA_RESET;
    end else if (wr_ctrl && bus.io_wdata[`NVM_BIT_READ] && !trig_q) begin
      data_q <= mem[addr_q[AW-1:0]]; // R14 R15 R4
    end else if (bus.io_wr && bus.io_addr == `NVM_OFS_DATA) begin
      data_q <= bus.io_wdata;
    end
  end

  // =====================================
  // control fields
  // mode is kept through reset while busy so the running job completes the operation it started
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rie_q <= 1'b0;
    end else if (wr_ctrl) begin
      rie_q <= bus.io_wdata[`NVM_BIT_RIE];
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst && !trig_q) begin
      mode_q <= nvm_pkg::prog_mode_t'(`NVM_MODE_RESET); // R7
    end else if (!i_rst && wr_ctrl && !trig_q) begin // R6
      mode_q <= nvm_pkg::prog_mode_t'(bus.io_wdata[`NVM_BIT_MODE_HI:`NVM_BIT_MODE_LO]);
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      arm_cnt_q <= 3'h0;
    end else if (wr_ctrl && bus.io_wdata[`NVM_BIT_ARM]) begin
      arm_cnt_q <= `NVM_ARM_CYCLES;
    end else if (arm_cnt_q != 3'h0) begin
      arm_cnt_q <= arm_cnt_q - 3'h1; // R9
    end
  end

  // =====================================
  // programming sequencer, not reset so a job survives reset
  // the byte is latched at start: reset clears the data register mid job
  always_ff @(posedge i_ref_clk) begin
    if (trig_q) begin // R1
      if (prog_cnt_q <= 32'h1) begin
        trig_q <= 1'b0; // R12
        unique case (mode_q)
          nvm_pkg::MODE_ATOMIC: mem[addr_q[AW-1:0]] <= prog_data_q;
          nvm_pkg::MODE_ERASE: mem[addr_q[AW-1:0]] <= `NVM_ERASED_BYTE;
          // unerased targets just and-in the new bits
          nvm_pkg::MODE_WRITE: mem[addr_q[AW-1:0]] <= mem[addr_q[AW-1:0]] & prog_data_q; // R19
          nvm_pkg::MODE_RSVD: ;
        endcase
      end
      prog_cnt_q <= prog_cnt_q - 32'h1;
    end else if (!i_rst && start) begin
      trig_q <= 1'b1; // R12
      prog_data_q <= data_q; // R1 R4
      prog_cnt_q <= (mode_q == nvm_pkg::MODE_ATOMIC) ? ATOMIC_CYC : SPLIT_CYC; // R5
    end
  end

  // =====================================
  // core stall and ready interrupt
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      stall_q <= 3'h0;
    end else if (start) begin
      stall_q <= `NVM_PROG_STALL; // R13
    end else if (wr_ctrl && bus.io_wdata[`NVM_BIT_READ] && !trig_q) begin
      stall_q <= `NVM_READ_STALL; // R14
    end else if (stall_q != 3'h0) begin
      stall_q <= stall_q - 3'h1;
    end
  end
  assign bus.stall = stall_q != 3'h0;
  assign bus.ready_irq = rie_q && bus.global_irq_en && !trig_q; // R8 R20

  // =====================================
  // read mux
  always_comb begin
    ctrl_rd = 8'h00; // R17
    ctrl_rd[`NVM_BIT_MODE_HI:`NVM_BIT_MODE_LO] = mode_q;
    ctrl_rd[`NVM_BIT_RIE] = rie_q;
    ctrl_rd[`NVM_BIT_ARM] = arm_cnt_q != 3'h0;
    ctrl_rd[`NVM_BIT_TRIG] = trig_q;
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      bus.io_rdata <= 8'h00;
    end else if (bus.io_rd) begin
      unique case (bus.io_addr)
        `NVM_OFS_CONTROL: bus.io_rdata <= ctrl_rd;
        `NVM_OFS_DATA: bus.io_rdata <= data_q;
        `NVM_OFS_ADDR_LO: bus.io_rdata <= addr_q[7:0];
        `NVM_OFS_ADDR_HI: bus.io_rdata <= {7'h00, addr_q[8]}; // R2
        default: bus.io_rdata <= 8'h00;
      endcase
    end
  end
endmodule : nvm_access_ctrl

/* nvm_core_master.sv */
// core end: apb slave whose commands run i/o-space sequences
`timescale 1ns/100ps
`include "nvm_params.svh"
module nvm_core_master (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  nvm_io_if.core io
);
  localparam logic [11:0] CMD_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam logic [1:0] OP_READ = 2'h1;
  localparam logic [1:0] OP_PROG = 2'h2;
  localparam logic [1:0] OP_HI = 2'h3;
  typedef enum logic [2:0] {IDLE, POLL, POLL_WAIT, SEQ, STALL} state_t;
  state_t state_q;
  logic [1:0] op_q;
  logic [1:0] mode_q;
  logic [8:0] addr_q;
  logic [7:0] data_q;
  logic [7:0] result_q;
  logic hi_q;
  logic gie_q;
  logic [2:0] step_q;
  logic acc;

  assign acc = i_psel && i_penable;
  assign o_pready = 1'b1;
  assign o_pslverr = acc && i_paddr != CMD_OFS && i_paddr != STAT_OFS;
  assign io.global_irq_en = gie_q;

  // =====================================
  // apb registers
  // command word: [8:0] addr, [16:9] data, [18:17] mode, [20:19] op, [21] gie
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= 32'h0;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      o_prdata <= (i_paddr == STAT_OFS) ?
        {20'h0, io.ready_irq, state_q != IDLE, 1'b0, hi_q, result_q} : 32'h0;
    end
  end

  // =====================================
  // sequencer
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= IDLE;
      op_q <= 2'h0;
      mode_q <= 2'h0;
      addr_q <= 9'h0;
      data_q <= 8'h0;
      result_q <= 8'h0;
      hi_q <= 1'b0;
      gie_q <= 1'b0;
      step_q <= 3'h0;
      io.io_addr <= 6'h0;
      io.io_wr <= 1'b0;
      io.io_rd <= 1'b0;
      io.io_wdata <= 8'h0;
    end else begin
      io.io_wr <= 1'b0;
      io.io_rd <= 1'b0;
      unique case (state_q)
        IDLE: begin
          if (acc && i_pwrite && i_paddr == CMD_OFS) begin
            addr_q <= i_pwdata[8:0];
            data_q <= i_pwdata[16:9];
            mode_q <= i_pwdata[18:17];
            op_q <= i_pwdata[20:19];
            gie_q <= i_pwdata[21];
            if (i_pwdata[20:19] == OP_READ || i_pwdata[20:19] == OP_PROG) begin
              state_q <= POLL;
            end
          end
        end
        POLL: begin
          io.io_addr <= `NVM_OFS_CONTROL; // R16
          io.io_rd <= 1'b1;
          state_q <= POLL_WAIT;
        end
        POLL_WAIT: begin
          if (!io.io_rd) begin
            if (io.io_rdata[`NVM_BIT_TRIG]) begin
              state_q <= POLL; // R16
            end else begin
              state_q <= SEQ;
              step_q <= 3'h0;
            end
          end
        end
        SEQ: begin
          // one i/o write per cycle; arm and trigger are separate steps
          io.io_wr <= 1'b1;
          step_q <= step_q + 3'h1;
          unique case (step_q)
            3'h0: begin
              io.io_addr <= `NVM_OFS_ADDR_HI; // R3
              io.io_wdata <= {7'h00, addr_q[8]};
            end
            3'h1: begin
              io.io_addr <= `NVM_OFS_ADDR_LO;
              io.io_wdata <= addr_q[7:0];
            end
            3'h2: begin
              io.io_addr <= (op_q == OP_PROG) ? `NVM_OFS_DATA : `NVM_OFS_CONTROL;
              // ready irq enable follows the command's global enable bit
              io.io_wdata <= (op_q == OP_PROG) ? data_q : {4'h0, gie_q, 3'h1};
              if (op_q != OP_PROG) begin
                state_q <= STALL;
              end
            end
            3'h3: begin
              io.io_addr <= `NVM_OFS_CONTROL;
              io.io_wdata <= {2'h0, mode_q, gie_q, 3'h0}; // R17
            end
            3'h4: begin
              io.io_addr <= `NVM_OFS_CONTROL;
              io.io_wdata <= {2'h0, mode_q, gie_q, 3'h4}; // R11
            end
            default: begin
              io.io_addr <= `NVM_OFS_CONTROL;
              io.io_wdata <= {2'h0, mode_q, gie_q, 3'h2}; // R11
              state_q <= STALL;
            end
          endcase
        end
        STALL: begin
          // a read also fetches the high address byte back for status
          if (!io.stall && !io.io_wr && !io.io_rd) begin
            if (op_q == OP_READ) begin
              io.io_addr <= `NVM_OFS_ADDR_HI; // R2
              io.io_rd <= 1'b1;
              op_q <= OP_HI;
            end else if (op_q == OP_HI) begin
              hi_q <= io.io_rdata[0]; // R3
              io.io_addr <= `NVM_OFS_DATA;
              io.io_rd <= 1'b1;
              op_q <= 2'h0;
            end else begin
              if (op_q == 2'h0) begin
                result_q <= io.io_rdata; // R4
              end
              state_q <= IDLE;
            end
          end
        end
      endcase
    end
  end
endmodule : nvm_core_master

/* nvm_io_if.sv */
// i/o-space register link between core-side master and controller
`timescale 1ns/100ps
interface nvm_io_if;
  logic [5:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic stall;
  logic ready_irq;
  logic global_irq_en;
  modport device (
    input io_addr, io_wr, io_rd, io_wdata, global_irq_en,
    output io_rdata, stall, ready_irq
  );
  modport core (
    output io_addr, io_wr, io_rd, io_wdata, global_irq_en,
    input io_rdata, stall, ready_irq
  );
endinterface : nvm_io_if

/* nvm_link_sva.sv */
// assertions on the i/o link between core master and controller
`timescale 1ns/100ps
module nvm_link_sva #(
  parameter int ATOMIC_CYC = 340000,
  parameter int SPLIT_CYC = 180000
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [5:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic stall,
  input wire logic ready_irq,
  input wire logic global_irq_en,
  input wire logic o_busy
);
  logic [2:0] arm_cnt_q;
  logic [31:0] busy_cnt_q;
  wire ctl_wr = io_wr && io_addr == 6'h1c;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // ==========================================
  // helper counters
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      arm_cnt_q <= 3'h0;
    end else if (ctl_wr && io_wdata[2] && !o_busy) begin
      arm_cnt_q <= 3'h4;
    end else if (arm_cnt_q != 3'h0) begin
      arm_cnt_q <= arm_cnt_q - 3'h1;
    end
  end
  // no reset: a running job outlives reset, so must its length
  always_ff @(posedge i_ref_clk) begin
    busy_cnt_q <= o_busy ? busy_cnt_q + 32'h1 : 32'h0;
  end
  // ==========================================
  // properties
  sequence s_prog_stall;
    stall [*2] ##1 !stall;
  endsequence
  sequence s_read_stall;
    stall [*4] ##1 !stall;
  endsequence
  a_irq_busy: assert property (o_busy |-> !ready_irq) else $error("irq while busy");
  a_irq_global: assert property (!global_irq_en |-> !ready_irq) else $error("irq without global");
  a_read_stall: assert property (ctl_wr && io_wdata[0] && !o_busy |=> s_read_stall) else $error("read stall");
  a_prog_stall: assert property ($rose(o_busy) |-> s_prog_stall) else $error("program stall");
  a_trig_armed: assert property ($rose(o_busy) |-> $past(ctl_wr && io_wdata[1]) && $past(arm_cnt_q) != 3'h0)
    else $error("start without arm");
  a_hi_addr_zero: assert property (io_rd && io_addr == 6'h1f |=> io_rdata[7:1] == 7'h0) else $error("addr hi");
  a_ctl_rsvd: assert property (io_rd && io_addr == 6'h1c |=> io_rdata[7:6] == 2'h0) else $error("ctl rsvd");
  a_trig_reads: assert property (io_rd && io_addr == 6'h1c |=> io_rdata[1] == $past(o_busy))
    else $error("trigger read");
  a_busy_len: assert property ($fell(o_busy) |-> busy_cnt_q >= SPLIT_CYC - 1 && busy_cnt_q <= ATOMIC_CYC + 1)
    else $error("program length");
endmodule : nvm_link_sva

/* nvm_params.svh */
// constants of the byte-wide nonvolatile access controller
// Contract
// (R1) reset never aborts running programming
// (R2) high address bits 7:1 read zero
// (R3) nine-bit linear address; software loads first
// (R4) data register feeds program, takes read byte
// (R5) mode field picks erase/write and duration
// (R6) mode writes ignored while trigger set
// (R7) reset clears mode unless programming
// (R8) ready interrupt level when enabled and global
// (R9) master arm self-clears after four cycles
// (R10) trigger starts only while arm still set
// (R11) software arms, then triggers, separately
// (R12) trigger stays set for programming time
// (R13) trigger start stalls core two cycles
// (R14) read strobe fetches byte, stalls four
// (R15) busy blocks reads and address changes
// (R16) software polls trigger clear before reading
// (R17) control bits 7:6 read zero
// (R18) busy refuses every other operation; data, ready-enable and arm writes are still taken while busy
// (R19) unerased write leaves content undefined
// (R20) ready equals trigger reading zero
`ifndef NVM_PARAMS_SVH
`define NVM_PARAMS_SVH
`define NVM_OFS_CONTROL 6'h1c
`define NVM_OFS_DATA 6'h1d
`define NVM_OFS_ADDR_LO 6'h1e
`define NVM_OFS_ADDR_HI 6'h1f
`define NVM_BIT_MODE_HI 5
`define NVM_BIT_MODE_LO 4
`define NVM_BIT_RIE 3
`define NVM_BIT_ARM 2
`define NVM_BIT_TRIG 1
`define NVM_BIT_READ 0
`define NVM_DATA_RESET 8'h00
`define NVM_MODE_RESET 2'h0
`define NVM_ERASED_BYTE 8'hff
`define NVM_ARM_CYCLES 3'h4
`define NVM_PROG_STALL 3'h2
`define NVM_READ_STALL 3'h4
`define NVM_CLK_MHZ 100
`define NVM_ATOMIC_US 3400
`define NVM_SPLIT_US 1800
`define NVM_ATOMIC_CYC (`NVM_ATOMIC_US * `NVM_CLK_MHZ)
`define NVM_SPLIT_CYC (`NVM_SPLIT_US * `NVM_CLK_MHZ)
`endif

/* nvm_pkg.sv */
// types used by the controller end of the nonvolatile access link and by the bench
package nvm_pkg;
  typedef enum logic [1:0] {
    MODE_ATOMIC = 2'h0,
    MODE_ERASE = 2'h1,
    MODE_WRITE = 2'h2,
    MODE_RSVD = 2'h3
  } prog_mode_t;
endpackage : nvm_pkg

/* tb_eeprom_access_controller.sv */
// self-checking bench: apb commands through core master into controller
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module tb_eeprom_access_controller;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  wire logic [31:0] prdata;
  wire logic pready;
  wire logic pslverr;
  wire logic busy;
  int err_total = 0;
  int cmp_count = 0;
  int seed = 32830;
  logic [7:0] exp_mem [512];
  logic [31:0] rdv;
  logic ev;
  nvm_io_if io_l ();
  nvm_access_ctrl #(.ATOMIC_CYC(40), .SPLIT_CYC(20)) nvm_access_ctrl_i (.i_ref_clk(ref_clk), .i_rst(rst),
    .bus(io_l), .o_busy(busy));
  nvm_core_master nvm_core_master_i (.i_ref_clk(ref_clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .io(io_l));
  nvm_link_sva #(.ATOMIC_CYC(40), .SPLIT_CYC(20)) chk_i (.i_ref_clk(ref_clk), .i_rst(rst),
    .io_addr(io_l.io_addr), .io_wr(io_l.io_wr), .io_rd(io_l.io_rd), .io_wdata(io_l.io_wdata),
    .io_rdata(io_l.io_rdata), .stall(io_l.stall), .ready_irq(io_l.ready_irq),
    .global_irq_en(io_l.global_irq_en), .o_busy(busy));
  always #5 ref_clk = ~ref_clk;
  // ==========================================
  // tasks
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rdv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_busy(input logic lvl, output logic hit);
    hit = 1'b0;
    for (int i = 0; i < 40 && !hit; i++) begin
      apb(1'b0, 12'h004, 32'h0);
      hit = (busy === lvl);
    end
  endtask : wait_busy
  function automatic logic [7:0] after(nvm_pkg::prog_mode_t m, logic [7:0] old, logic [7:0] d);
    case (m)
      nvm_pkg::MODE_ATOMIC: after = d;
      nvm_pkg::MODE_ERASE: after = 8'hff;
      nvm_pkg::MODE_WRITE: after = old & d;
      default: after = old;
    endcase
  endfunction : after
  task automatic prog(input logic [8:0] a, input logic [7:0] d, input nvm_pkg::prog_mode_t m, input logic rs);
    logic hit;
    apb(1'b1, 12'h000, {10'h0, 1'b1, 2'h2, m, d, a});
    wait_busy(1'b1, hit);
    `CHK(hit, m != nvm_pkg::MODE_RSVD)
    if (hit) begin
      apb(1'b0, 12'h004, 32'h0);
      `CHK(rdv[11], 1'b0)
      if (rs) begin
        rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        `CHK(busy, 1'b1)
      end
      wait_busy(1'b0, hit);
      `CHK(hit, 1'b1)
      apb(1'b0, 12'h004, 32'h0);
      `CHK(rdv[11], !rs)
      exp_mem[a] = after(m, exp_mem[a], d);
    end
  endtask : prog
  task automatic rd(input logic [8:0] a);
    apb(1'b1, 12'h000, {10'h0, 1'b0, 2'h1, 2'h0, 8'h0, a});
    // wait for the sequence to finish so a stale byte cannot pass
    for (int i = 0; i < 40; i++) begin
      apb(1'b0, 12'h004, 32'h0);
      if (rdv[10] === 1'b0) break;
    end
    `CHK(rdv[10], 1'b0)
    `CHK(rdv[8], a[8])
    `CHK(rdv[7:0], exp_mem[a])
  endtask : rd
  // ==========================================
  // main sequence
  initial begin
    logic [8:0] a;
    logic [7:0] d;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    apb(1'b0, 12'h004, 32'h0);
    `CHK(rdv[11:10], 2'h0)
    apb(1'b0, 12'h008, 32'h0);
    `CHK(ev, 1'b1)
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 9'h000 : (i == 1) ? 9'h1ff : 9'($random(seed));
      d = 8'($random(seed));
      prog(a, d, nvm_pkg::MODE_ATOMIC, 1'b0);
      rd(a);
    end
    $display("test atomic done");
    prog(a, 8'h00, nvm_pkg::MODE_ERASE, 1'b0);
    rd(a);
    prog(a, d, nvm_pkg::MODE_WRITE, 1'b0);
    rd(a);
    prog(a, 8'h5a, nvm_pkg::MODE_WRITE, 1'b0);
    rd(a);
    prog(a, ~d, nvm_pkg::MODE_RSVD, 1'b0);
    rd(a);
    $display("test split done");
    prog(9'h0c8, 8'ha7, nvm_pkg::MODE_ATOMIC, 1'b1);
    rd(9'h0c8);
    $display("test reset mid job done");
    conclude();
  end
  // run should need well under this many cycles
  initial begin
    repeat (50000) @(posedge ref_clk);
    err_total++;
    conclude();
  end
endmodule : tb_eeprom_access_controller
